// [hdl/rsba_alu.sv]
/*
 * Accumulator datapath: real subtract (operand minus accumulator) and
 * 16/32-bit BCD multiply, with discrete status flags, a register port
 * and a masked level interrupt.
 * Assumes the sequencer and the register master share CLK_SYS, so
 * none of their inputs are synchronised.
 */
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

// Operation
// (RULE_01) Real subtract: operand minus accumulator, to accumulator
// (RULE_02) Both values are IEEE single precision
// (RULE_03) Zero flag follows accumulator equal zero
// (RULE_04) Negative flag set when accumulator negative
// (RULE_05) Bad pointer flag on invalid pointer target; only a subtract checks it, a multiply ignores the pointer fields
// (RULE_06) Validity flag on for valid float accumulator; code also clears it for a non-real operand
// (RULE_07) Sign error flag on signed overflow
// (RULE_08) Underflow flag on floating point underflow
// (RULE_09) Bad format flag on non-real operand
// (RULE_10) Bad format flag on non-BCD multiply operand
// (RULE_11) Flags hold until next affecting operation
// (RULE_12) Single multiply uses accumulator low 16 bits
// (RULE_13) Single multiply: eight-digit product to accumulator
// (RULE_14) Issuer gives one word or 1..9999
// (RULE_15) Wide multiply: eight by eight BCD digits
// (RULE_16) Wide multiply: lower eight digits to accumulator
// (RULE_17) Wide multiply: upper digits pushed on stack
// (RULE_18) Non-BCD means any digit above nine
// (RULE_19) Round to nearest even subtraction
module rsba_alu
	import rsba_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [DATA_W-1:0] REG_RDATA,
	input wire logic OP_START,
	input wire rsba_req_t OP_REQ,
	output logic OP_BUSY,
	output logic OP_DONE,
	output logic [DATA_W-1:0] ACC_VALUE,
	output logic STACK_PUSH,
	output logic [DATA_W-1:0] STACK_DATA,
	output rsba_flags_t FLAGS,
	output logic IRQ
);

	function automatic logic [PROD_W-1:0] bcd_add(
		input logic [PROD_W-1:0] x,
		input logic [PROD_W-1:0] y
	);
		logic [PROD_W-1:0] r;
		logic [DIGIT_W:0] s;
		logic c;
		r = '0;
		c = 1'b0;
		for (int i = 0; i < PROD_W / DIGIT_W; i++) begin
			s = {1'b0, x[i*DIGIT_W +: DIGIT_W]} +
				{1'b0, y[i*DIGIT_W +: DIGIT_W]} + {4'h0, c};
			if (s > {1'b0, BCD_DIGIT_MAX}) begin
				s = s + BCD_ADJUST;
				c = 1'b1;
			end else begin
				c = 1'b0;
			end
			r[i*DIGIT_W +: DIGIT_W] = s[DIGIT_W-1:0];
		end
		return r;
	endfunction : bcd_add

	// Minuend minus subtrahend, round to nearest even, subnormals kept
	function automatic rsba_fres_t real_sub(
		input logic [DATA_W-1:0] minuend,
		input logic [DATA_W-1:0] subtrahend
	);
		rsba_fres_t r;
		logic [DATA_W-1:0] x, y, big, sml;
		logic s_big, eff_sub, sticky, tiny, rnd_up;
		logic [7:0] e_big, e_sml, d;
		logic [F_MANT_W:0] m_big, m_sml;
		logic [F_WORK_W-1:0] sh;
		logic [F_WORK_W:0] sum;
		logic [F_MANT_W+1:0] mant_r;
		logic [9:0] e;
		x = minuend;
		y = {~subtrahend[F_SIGN], subtrahend[F_SIGN-1:0]};
		if (x[F_SIGN-1:0] >= y[F_SIGN-1:0]) begin
			big = x;
			sml = y;
		end else begin
			big = y;
			sml = x;
		end
		s_big = big[F_SIGN];
		eff_sub = big[F_SIGN] ^ sml[F_SIGN];
		e_big = (big[F_EXP_HI:F_EXP_LO] == F_EXP_ZERO) ? F_EXP_MIN
			: big[F_EXP_HI:F_EXP_LO];
		e_sml = (sml[F_EXP_HI:F_EXP_LO] == F_EXP_ZERO) ? F_EXP_MIN
			: sml[F_EXP_HI:F_EXP_LO];
		m_big = {big[F_EXP_HI:F_EXP_LO] != F_EXP_ZERO, big[F_MANT_W-1:0]};
		m_sml = {sml[F_EXP_HI:F_EXP_LO] != F_EXP_ZERO, sml[F_MANT_W-1:0]};
		d = e_big - e_sml;
		sh = {m_sml, 3'b000};
		sticky = 1'b0;
		// Bounded shift keeps the loop short; beyond it all bits are sticky
		for (int i = 0; i < F_WORK_W; i++) begin
			if (i < int'(d)) begin
				sticky = sticky | sh[0];
				sh = sh >> 1;
			end
		end
		sh[0] = sh[0] | sticky;
		if (eff_sub) begin
			sum = {1'b0, m_big, 3'b000} - {1'b0, sh};
		end else begin
			sum = {1'b0, m_big, 3'b000} + {1'b0, sh};
		end
		e = {2'b00, e_big};
		if (sum[F_WORK_W]) begin
			sum = {1'b0, sum[F_WORK_W:2], sum[1] | sum[0]};
			e = e + 10'd1;
		end
		for (int i = 0; i < F_WORK_W - 1; i++) begin
			if (!sum[F_WORK_W-1] && e > {2'b00, F_EXP_MIN}) begin
				sum = sum << 1;
				e = e - 10'd1;
			end
		end
		tiny = !sum[F_WORK_W-1];
		// A subnormal difference is always exact, so tininess alone counts
		rnd_up = sum[2] & (sum[1] | sum[0] | sum[3]); // RULE_19
		mant_r = {1'b0, sum[F_WORK_W-1:3]} + {24'h00_0000, rnd_up};
		if (mant_r[F_MANT_W+1]) begin
			mant_r = mant_r >> 1;
			e = e + 10'd1;
		end
		r.underflow = tiny & |sum; // RULE_08
		r.overflow = 1'b0;
		if (sum == '0) begin
			r.value = '0;
		end else if (e >= F_EXP_OVF) begin
			r.value = {s_big, F_EXP_ONES, 23'h00_0000};
			r.overflow = 1'b1; // RULE_07
		end else begin
			r.value = {s_big, mant_r[F_MANT_W] ? e[7:0] : F_EXP_ZERO,
				mant_r[F_MANT_W-1:0]};
		end
		return r;
	endfunction : real_sub

	rsba_state_t state_reg, state_next;
	logic [DATA_W-1:0] acc_reg;
	logic [DATA_W-1:0] stack_reg;
	rsba_flags_t flags_reg;
	logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic irq_reg, busy_reg, done_reg, push_reg;
	logic [PROD_W-1:0] prod_reg, mcand_reg;
	logic [DATA_W-1:0] mplier_reg;
	logic [3:0] digit_cnt_reg, add_cnt_reg;
	logic wide_reg;

	logic start_ok, is_sub, is_mul, is_wide;
	logic [WIDE_DIGITS-1:0] opnd_bad_digit, acc_bad_digit;
	logic bcd_bad, real_bad, sub_commit;
	rsba_fres_t fres;
	logic [DATA_W-1:0] mul_result;
	logic acc_wr, err_event, done_event;

	assign start_ok = OP_START && (state_reg == ST_IDLE);
	assign is_sub = OP_REQ.opcode == OP_REAL_SUBTRACT;
	assign is_wide = OP_REQ.opcode == OP_BCD_MULTIPLY_WIDE;
	assign is_mul = (OP_REQ.opcode == OP_BCD_MULTIPLY_SINGLE) || is_wide;

	genvar g;
	generate
		for (g = 0; g < WIDE_DIGITS; g++) begin : g_digit
			assign opnd_bad_digit[g] =
				OP_REQ.operand[g*DIGIT_W +: DIGIT_W] > BCD_DIGIT_MAX; // RULE_18
			assign acc_bad_digit[g] =
				acc_reg[g*DIGIT_W +: DIGIT_W] > BCD_DIGIT_MAX; // RULE_18
		end
	endgenerate

	// Single multiply checks only the low four digits of each side
	assign bcd_bad = is_wide ? (|opnd_bad_digit || |acc_bad_digit)
		: (|opnd_bad_digit[SINGLE_DIGITS-1:0]
		|| |acc_bad_digit[SINGLE_DIGITS-1:0]); // RULE_10

	// Infinity and NaN are not accepted as real numbers
	assign real_bad =
		(OP_REQ.operand[F_EXP_HI:F_EXP_LO] == F_EXP_ONES) ||
		(acc_reg[F_EXP_HI:F_EXP_LO] == F_EXP_ONES); // RULE_09

	assign fres = real_sub(OP_REQ.operand, acc_reg); // RULE_01 RULE_02
	assign sub_commit = start_ok && is_sub && !real_bad &&
		!(OP_REQ.via_pointer && !OP_REQ.pointer_ok);
	assign mul_result = prod_reg[DATA_W-1:0];

	// Operations own the accumulator; a bus write loses to them
	assign acc_wr = REG_WR && (REG_ADDR == REG_ACC) &&
		(state_reg == ST_IDLE) && !OP_START;

	assign done_event = (start_ok && !(is_mul && !bcd_bad)) ||
		(state_reg == ST_FINISH);
	assign err_event = start_ok && (
		(is_sub && ((OP_REQ.via_pointer && !OP_REQ.pointer_ok) ||
		real_bad || fres.overflow || fres.underflow)) ||
		(is_mul && bcd_bad));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_ok && is_mul && !bcd_bad) begin
					state_next = ST_MUL_SHIFT;
				end
			end
			ST_MUL_SHIFT: begin
				state_next = ST_MUL_ADD;
			end
			ST_MUL_ADD: begin
				if (add_cnt_reg == 4'h0 && digit_cnt_reg == 4'h0) begin
					state_next = ST_FINISH;
				end else if (add_cnt_reg == 4'h0) begin
					state_next = ST_MUL_SHIFT;
				end
			end
			ST_FINISH: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Shift-and-add: one digit shift, then one BCD add per cycle
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			prod_reg <= '0;
			mcand_reg <= '0;
			mplier_reg <= '0;
			digit_cnt_reg <= 4'h0;
			add_cnt_reg <= 4'h0;
			wide_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_ok && is_mul && !bcd_bad) begin
						prod_reg <= '0;
						wide_reg <= is_wide;
						add_cnt_reg <= 4'h0;
						if (is_wide) begin
							mcand_reg <= {32'h0000_0000, acc_reg}; // RULE_15
							mplier_reg <= OP_REQ.operand;
							digit_cnt_reg <= 4'(WIDE_DIGITS);
						end else begin
							mcand_reg <= {48'h0000_0000_0000,
								acc_reg[15:0]}; // RULE_12
							mplier_reg <= {OP_REQ.operand[15:0],
								16'h0000};
							digit_cnt_reg <= 4'(SINGLE_DIGITS);
						end
					end
				end
				ST_MUL_SHIFT: begin
					prod_reg <= prod_reg << DIGIT_W;
					add_cnt_reg <= mplier_reg[DATA_W-1 -: DIGIT_W];
					mplier_reg <= mplier_reg << DIGIT_W;
					digit_cnt_reg <= digit_cnt_reg - 4'h1;
				end
				ST_MUL_ADD: begin
					if (add_cnt_reg != 4'h0) begin
						prod_reg <= bcd_add(prod_reg, mcand_reg);
						add_cnt_reg <= add_cnt_reg - 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			acc_reg <= ACC_RESET;
		end else if (sub_commit) begin
			acc_reg <= fres.value; // RULE_01
		end else if (state_reg == ST_FINISH) begin
			acc_reg <= mul_result; // RULE_13 RULE_16
		end else if (acc_wr) begin
			acc_reg <= REG_WDATA;
		end
	end

	// Stack entry sees the upper eight product digits of a wide multiply
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			stack_reg <= '0;
			push_reg <= 1'b0;
		end else begin
			push_reg <= (state_reg == ST_FINISH) && wide_reg;
			if (state_reg == ST_FINISH && wide_reg) begin
				stack_reg <= prod_reg[PROD_W-1:DATA_W]; // RULE_17
			end
		end
	end

	// Only the flags an operation touches are rewritten
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			flags_reg <= FLAGS_RESET;
		end else if (start_ok && is_sub) begin
			flags_reg.bad_pointer_flag <=
				OP_REQ.via_pointer && !OP_REQ.pointer_ok; // RULE_05
			flags_reg.bad_operand_format_flag <= real_bad; // RULE_09
			if (sub_commit) begin
				flags_reg.zero_result_flag <=
					fres.value[F_SIGN-1:0] == '0; // RULE_03
				flags_reg.negative_result_flag <=
					fres.value[F_SIGN]; // RULE_04
				flags_reg.float_validity_flag <=
					fres.value[F_EXP_HI:F_EXP_LO] != F_EXP_ONES; // RULE_06
				flags_reg.sign_error_flag <= fres.overflow; // RULE_07
				flags_reg.float_underflow_flag <= fres.underflow; // RULE_08
			end else begin
				flags_reg.zero_result_flag <=
					acc_reg[F_SIGN-1:0] == '0; // RULE_03
				flags_reg.negative_result_flag <= acc_reg[F_SIGN]; // RULE_04
				flags_reg.float_validity_flag <= !real_bad; // RULE_06
				flags_reg.sign_error_flag <= 1'b0; // RULE_11
				flags_reg.float_underflow_flag <= 1'b0; // RULE_11
			end
		end else if (start_ok && is_mul && bcd_bad) begin
			flags_reg.bad_operand_format_flag <= 1'b1; // RULE_10
			flags_reg.zero_result_flag <= acc_reg == '0; // RULE_03
			flags_reg.negative_result_flag <= acc_reg[F_SIGN]; // RULE_04
		end else if (state_reg == ST_FINISH) begin
			flags_reg.bad_operand_format_flag <= 1'b0; // RULE_11
			flags_reg.zero_result_flag <= mul_result == '0; // RULE_03
			flags_reg.negative_result_flag <= mul_result[F_SIGN]; // RULE_04
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			busy_reg <= state_next != ST_IDLE;
			done_reg <= done_event;
		end
	end

	// Set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= IRQ_MASK_RESET;
		end else begin
			for (int i = 0; i < IRQ_W; i++) begin
				if (REG_WR && REG_ADDR == REG_IRQ_STAT && REG_WDATA[i]) begin
					irq_stat_reg[i] <= 1'b0;
				end
			end
			if (done_event) begin
				irq_stat_reg[IRQ_DONE_BIT] <= 1'b1;
			end
			if (err_event) begin
				irq_stat_reg[IRQ_ERR_BIT] <= 1'b1;
			end
			if (REG_WR && REG_ADDR == REG_IRQ_MASK) begin
				irq_mask_reg <= REG_WDATA[IRQ_W-1:0];
			end
		end
	end

	// Level output lags the status bits by one cycle
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rdata_reg <= '0;
		end else if (REG_RD) begin
			case (REG_ADDR)
				REG_ACC: rdata_reg <= acc_reg;
				REG_STACK: rdata_reg <= stack_reg;
				REG_FLAGS: rdata_reg <= {25'h000_0000, flags_reg};
				REG_IRQ_STAT: rdata_reg <= {30'h0000_0000, irq_stat_reg};
				REG_IRQ_MASK: rdata_reg <= {30'h0000_0000, irq_mask_reg};
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	assign REG_RDATA = rdata_reg;
	assign OP_BUSY = busy_reg;
	assign OP_DONE = done_reg;
	assign ACC_VALUE = acc_reg;
	assign STACK_PUSH = push_reg;
	assign STACK_DATA = stack_reg;
	assign FLAGS = flags_reg;
	assign IRQ = irq_reg;

endmodule : rsba_alu

// [hdl/rsba_pkg.sv]
/*
 * Shared constants and types for the real-subtract / BCD-multiply datapath:
 * register map, flag and request layouts, opcodes, FSM states.
 * Assumes a single system clock and a sequencer on the same clock.
 */
package rsba_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int DIGIT_W = 4;
	localparam int SINGLE_DIGITS = 4;
	localparam int WIDE_DIGITS = 8;
	localparam int PROD_W = 64;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_ACC = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STACK = 8'h04;
	localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h10;

	// Interrupt status / mask bit positions
	localparam int IRQ_W = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;

	localparam logic [DATA_W-1:0] ACC_RESET = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

	// BCD digit limits
	localparam logic [DIGIT_W-1:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [DIGIT_W:0] BCD_ADJUST = 5'h06;

	// Single precision layout
	localparam int F_SIGN = 31;
	localparam int F_EXP_HI = 30;
	localparam int F_EXP_LO = 23;
	localparam int F_MANT_W = 23;
	localparam logic [7:0] F_EXP_ZERO = 8'h00;
	localparam logic [7:0] F_EXP_ONES = 8'hFF;
	localparam logic [7:0] F_EXP_MIN = 8'h01;
	localparam logic [9:0] F_EXP_OVF = 10'h0FF;
	localparam int F_WORK_W = 27;

	typedef enum logic [1:0] {
		OP_REAL_SUBTRACT = 2'b00,
		OP_BCD_MULTIPLY_SINGLE = 2'b01,
		OP_BCD_MULTIPLY_WIDE = 2'b10
	} rsba_opcode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MUL_SHIFT = 2'b01,
		ST_MUL_ADD = 2'b10,
		ST_FINISH = 2'b11
	} rsba_state_t;

	typedef struct packed {
		rsba_opcode_t opcode;
		logic [DATA_W-1:0] operand;
		logic via_pointer;
		logic pointer_ok;
	} rsba_req_t;

	// Bit 0 is the zero flag, bit 6 the bad-format flag
	typedef struct packed {
		logic bad_operand_format_flag;
		logic float_underflow_flag;
		logic sign_error_flag;
		logic float_validity_flag;
		logic bad_pointer_flag;
		logic negative_result_flag;
		logic zero_result_flag;
	} rsba_flags_t;

	localparam int FLAGS_W = 7;
	localparam rsba_flags_t FLAGS_RESET = 7'h00;

	typedef struct packed {
		logic [DATA_W-1:0] value;
		logic underflow;
		logic overflow;
	} rsba_fres_t;

endpackage : rsba_pkg

// [tb/rsba_alu_sva.sv]
/* Port checker for the datapath: op timing, flags, read port, interrupt.
 Assumes it is bound to rsba_alu and shares its single clock. */
`timescale 1ns/10ps
module rsba_alu_sva
	import rsba_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic OP_START,
	input wire rsba_req_t OP_REQ,
	input wire logic OP_BUSY,
	input wire logic OP_DONE,
	input wire logic [DATA_W-1:0] ACC_VALUE,
	input wire logic STACK_PUSH,
	input wire rsba_flags_t FLAGS,
	input wire logic IRQ
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	logic go;
	logic sub;
	logic mul;
	// Busy covers the finish cycle, so this is exactly an accepted start
	assign go = OP_START && !OP_BUSY;
	assign sub = go && OP_REQ.opcode == OP_REAL_SUBTRACT;
	assign mul = go && (OP_REQ.opcode[1] ^ OP_REQ.opcode[0]);
	a_sub_done: assert property (sub |=> OP_DONE)
		else $error("subtract not done next cycle");
	a_bad_ptr: assert property (sub && OP_REQ.via_pointer &&
		!OP_REQ.pointer_ok |=> FLAGS.bad_pointer_flag && $stable(ACC_VALUE))
		else $error("bad pointer not flagged");
	a_ptr_clear: assert property (sub && !OP_REQ.via_pointer
		|=> !FLAGS.bad_pointer_flag)
		else $error("bad pointer flag not overwritten");
	a_zero_flag: assert property (OP_DONE && !FLAGS.bad_pointer_flag
		|-> FLAGS.zero_result_flag == (ACC_VALUE == '0))
		else $error("zero flag wrong");
	a_neg_flag: assert property (OP_DONE && !FLAGS.bad_pointer_flag
		|-> FLAGS.negative_result_flag == ACC_VALUE[31])
		else $error("negative flag wrong");
	a_mul_bound: assert property (mul |-> ##[1:95] OP_DONE)
		else $error("multiply did not finish");
	a_bcd_bad: assert property (mul && OP_REQ.operand[3:0] > 4'h9
		|=> FLAGS.bad_operand_format_flag && $stable(ACC_VALUE))
		else $error("non-BCD digit not flagged");
	a_push_done: assert property (STACK_PUSH |-> OP_DONE)
		else $error("stack push outside done");
	a_busy_end: assert property ($fell(OP_BUSY) |-> OP_DONE)
		else $error("busy ended without done");
	// A mask write shows on the pin one edge after it is taken
	a_irq_cause: assert property ($rose(IRQ) |->
		$past(OP_DONE) || $past(REG_WR, 2))
		else $error("interrupt rose without cause");
	a_rd_idle: assert property (!REG_RD |=> REG_RDATA == '0)
		else $error("read data outside read cycle");
	a_flags_rd: assert property (REG_RD && REG_ADDR == REG_FLAGS
		|=> REG_RDATA == {25'h0, $past(FLAGS)})
		else $error("flag read mismatch");
endmodule : rsba_alu_sva

bind rsba_alu rsba_alu_sva i_sva (.CLK_SYS, .RESETN, .REG_ADDR, .REG_WR,
	.REG_RD, .REG_RDATA, .OP_START, .OP_REQ, .OP_BUSY, .OP_DONE, .ACC_VALUE,
	.STACK_PUSH, .FLAGS, .IRQ);

// [tb/rsba_alu_tb_top.sv]
/* Testbench for the datapath: subtract, multiply, registers, interrupt.
 Assumes the port checker is bound from its own file. */
`timescale 1ns/10ps
module rsba_alu_tb_top import rsba_pkg::*; ();
	logic CLK_SYS = 1'b0;
	logic RESETN = 1'b0;
	logic [ADDR_W-1:0] REG_ADDR = '0;
	logic [DATA_W-1:0] REG_WDATA = '0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic OP_START = 1'b0;
	rsba_req_t OP_REQ = '0;
	logic [DATA_W-1:0] REG_RDATA, ACC_VALUE, STACK_DATA;
	logic OP_BUSY, OP_DONE, STACK_PUSH, IRQ;
	rsba_flags_t FLAGS;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	rsba_alu i_dut (.CLK_SYS, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR,
		.REG_RD, .REG_RDATA, .OP_START, .OP_REQ, .OP_BUSY, .OP_DONE,
		.ACC_VALUE, .STACK_PUSH, .STACK_DATA, .FLAGS, .IRQ);
	always #5 CLK_SYS = ~CLK_SYS;
	task automatic complete_run();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		// Ceiling well above the longest multiply table
		if (cyc == 5000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(input logic [DATA_W-1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1 chk(REG_RDATA, e);
	endtask : rdc
	// Drop variant fires a subtract while busy; it must be ignored
	task automatic op(input rsba_opcode_t c, input logic [DATA_W-1:0] v,
		input logic p, k, drop);
		@(posedge CLK_SYS);
		OP_START <= 1'b1;
		OP_REQ <= '{c, v, p, k};
		for (int n = 0; n < 100; n++) begin
			@(posedge CLK_SYS);
			OP_START <= drop && n == 1;
			if (n == 1) OP_REQ.opcode <= OP_REAL_SUBTRACT;
			#1;
			if (OP_DONE === 1'b1) break;
		end
		chk(OP_DONE, 1'b1);
	endtask : op
	task automatic t_sub();
		logic [31:0] t [8][4] = '{
			'{32'h3F800000, 32'h40400000, 32'h80000404, 32'h3F800000},
			'{32'h3F800000, 32'h40400000, 32'h00007F08, 32'h40000000},
			'{32'h40000000, 32'h40000000, 32'h00007F09, 32'h00000000},
			'{32'h40400000, 32'h3F800000, 32'h00007F0A, 32'hC0000000},
			'{32'h33800000, 32'h3F800001, 32'h00007F08, 32'h3F800000},
			'{32'hFF7FFFFF, 32'h7F7FFFFF, 32'h00007F10, 32'h7F800000},
			'{32'h00800000, 32'h00C00000, 32'h00007F28, 32'h00400000},
			'{32'h3F800000, 32'h7FC00000, 32'h00004840, 32'h3F800000}};
		for (int i = 0; i < 8; i++) begin
			wr(REG_ACC, t[i][0]);
			op(OP_REAL_SUBTRACT, t[i][1], t[i][2][31], !t[i][2][31], 1'b0);
			chk(ACC_VALUE, t[i][3]);
			chk({25'h0, FLAGS & t[i][2][14:8]}, {25'h0, t[i][2][6:0]});
		end
	endtask : t_sub
	task automatic t_mul();
		logic push;
		logic [31:0] m [11][5] = '{
			'{32'hFFFF0012, 32'h00000034, 32'h00000408, 0, 32'h0100},
			'{32'h00009999, 32'h00009999, 32'h99980001, 0, 32'h0102},
			'{32'h00000000, 32'h00000005, 32'h00000000, 0, 32'h0101},
			'{32'h00000002, 32'h0000000A, 32'h00000002, 0, 32'h0140},
			'{32'h00000002, 32'h000000A0, 32'h00000002, 0, 32'h0140},
			'{32'h00000002, 32'h00000A00, 32'h00000002, 0, 32'h0140},
			'{32'h00000002, 32'h0000A000, 32'h00000002, 0, 32'h0140},
			'{32'h0000000B, 32'h00000001, 32'h0000000B, 0, 32'h0140},
			'{32'h12345678, 32'h00000002, 32'h24691356, 0, 32'h0200},
			'{32'h99999999, 32'h99999999, 32'h00000001, 32'h99999998, 32'h0200},
			'{32'h00000002, 32'hF0000000, 32'h00000002, 0, 32'h0240}};
		for (int i = 0; i < 11; i++) begin
			wr(REG_ACC, m[i][0]);
			op(rsba_opcode_t'(m[i][4][9:8]), m[i][1], 1'b0, 1'b1, i == 8);
			push = m[i][4][9] && !m[i][4][6];
			chk(ACC_VALUE, m[i][2]);
			chk({25'h0, FLAGS & 7'h4B}, {25'h0, m[i][4][6:0]});
			chk(STACK_PUSH, push);
			if (push) chk(STACK_DATA, m[i][3]);
		end
	endtask : t_mul
	task automatic t_irq();
		wr(REG_STACK, 32'h0);
		rdc(REG_STACK, 32'h99999998);
		rdc(8'h14, 32'h0);
		chk(IRQ, 1'b0);
		rdc(REG_IRQ_STAT, 32'h3);
		wr(REG_IRQ_STAT, 32'h3);
		rdc(REG_IRQ_STAT, 32'h0);
		wr(REG_IRQ_MASK, 32'h1);
		rdc(REG_IRQ_MASK, 32'h1);
		wr(REG_ACC, 32'h3F800000);
		op(OP_REAL_SUBTRACT, 32'h40400000, 1'b0, 1'b1, 1'b0);
		@(posedge CLK_SYS);
		#1 chk(IRQ, 1'b1);
		wr(REG_IRQ_STAT, 32'h1);
		@(posedge CLK_SYS);
		#1 chk(IRQ, 1'b0);
		wr(REG_IRQ_MASK, 32'h2);
		op(OP_REAL_SUBTRACT, 32'h40400000, 1'b1, 1'b0, 1'b0);
		@(posedge CLK_SYS);
		#1 chk(IRQ, 1'b1);
		rdc(REG_IRQ_STAT, 32'h3);
		wr(REG_IRQ_MASK, 32'h0);
		@(posedge CLK_SYS);
		#1 chk(IRQ, 1'b0);
	endtask : t_irq
	initial begin
		repeat (6) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		#1 chk(ACC_VALUE, ACC_RESET);
		rdc(REG_FLAGS, 32'h0);
		rdc(REG_IRQ_MASK, 32'h0);
		t_sub();
		t_mul();
		t_irq();
		complete_run();
	end
endmodule : rsba_alu_tb_top
